/* File: shared/halt_monitor_pkg.sv */
package halt_monitor_pkg;

    // Timing figures in their own units and the derived cycle counts
    localparam int CLK_HZ      = 200_000_000;
    localparam int T_AGREE_MS  = 100;
    localparam int T_LIMIT_MS  = 1000;
    localparam int T_RESP_MS   = 12;
    localparam int AGREE_CYC   = CLK_HZ / 1000 * T_AGREE_MS;
    localparam int LIMIT_CYC   = CLK_HZ / 1000 * T_LIMIT_MS;
    localparam int RESP_CYC    = CLK_HZ / 1000 * T_RESP_MS;
    localparam int CNT_W       = 28;

    // Register map, word indices on the Avalon slave (byte address bits 4:2)
    localparam int           ADDR_W      = 5;
    localparam logic [2:0]   IDX_CTRL    = 3'h0;
    localparam logic [2:0]   IDX_STATUS  = 3'h1;
    localparam logic [2:0]   IDX_FAULT   = 3'h2;
    localparam logic [2:0]   IDX_IRQ_ST  = 3'h3;
    localparam logic [2:0]   IDX_IRQ_CLR = 3'h4;
    localparam logic [2:0]   IDX_IRQ_EN  = 3'h5;

    // Control register fields
    localparam int CTRL_HW_MODE   = 0;
    localparam int CTRL_FAULT_RST = 1;

    // Guard status word fields
    localparam int ST_GUARD_OK    = 0;
    localparam int ST_GATE_PERMIT = 2;
    localparam int ST_INPUTS_ON   = 3;
    localparam int ST_HALT_REQ    = 4;
    localparam int ST_START_INH   = 5;

    // Guard fault word field
    localparam int FLT_DISCREP    = 9;

    // Interrupt event bits
    localparam int EV_HALT        = 0;
    localparam int EV_FAULT       = 1;

    typedef enum logic [2:0] {
        ST_RUN      = 3'b000,
        ST_OFF_WAIT = 3'b001,
        ST_BOTH_OFF = 3'b010,
        ST_ON_WAIT  = 3'b011,
        ST_ON_LATE  = 3'b100
    } mon_state_e;

    typedef struct packed {
        logic              read;
        logic              write;
        logic [ADDR_W-1:0] address;
        logic [31:0]       writedata;
        logic [3:0]        byteenable;
    } avs_req_s;

    typedef struct packed {
        mon_state_e        state;
        logic [CNT_W-1:0]  cnt;
        logic [1:0]        a_sync;
        logic [1:0]        b_sync;
        logic              hw_mode;
        logic              fault;
        logic              halt;
        logic              gate_en;
        logic [1:0]        irq_status;
        logic [1:0]        irq_en;
        logic              irq;
        logic              waitreq;
        logic [31:0]       rdata;
    } mon_regs_s;

    localparam mon_regs_s REGS_RESET = '{
        state: ST_BOTH_OFF, cnt: '0, a_sync: 2'h0, b_sync: 2'h0,
        hw_mode: 1'b0, fault: 1'b0, halt: 1'b1, gate_en: 1'b0,
        irq_status: 2'h0, irq_en: 2'h0, irq: 1'b0, waitreq: 1'b1, rdata: 32'h0
    };

endpackage : halt_monitor_pkg

/* File: core/safe_halt_monitor.sv */
// Notes on behaviour
// [RQ1] Either safety input dropping forces every gate-drive signal off.
// [RQ2] Torque is disabled well within 12 ms of an input dropping.
// [RQ3] Halt request flag sets as soon as one input is off.
// [RQ4] Any input off shows start inhibit and halt request as 1.
// [RQ5] Second input not off within 100 ms of first posts discrepancy fault.
// [RQ6] No fault when second input returns within 1 s of first.
// [RQ7] Halt clears at once within 100 ms, else at the 1 s mark.
// [RQ8] Fault also posts if first input returns before second ever dropped.
// [RQ9] Fault reset accepted only after both inputs off for over 1 s.
// [RQ10] Controller must issue an explicit fault reset; no self clearing.
// [RQ11] Inputs govern torque only in hardwired mode, selected by controller.
// [RQ12] Channel faults are checked only on demand, never while running.
// [RQ13] Halt or fault shows gate permit disabled and guard not OK.
//
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps
module safe_halt_monitor
    import halt_monitor_pkg::*;
#(
    parameter int AGREE_CYCLES = AGREE_CYC,
    parameter int LIMIT_CYCLES = LIMIT_CYC
)
(
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        safe_halt_input_a_i,
    input  wire logic        safe_halt_input_b_i,
    input  wire avs_req_s    avs_req_i,
    output logic [31:0]      avs_readdata_o,
    output logic             avs_waitrequest_o,
    output logic             gate_drive_enable_o,
    output logic             halt_request_o,
    output logic             discrepancy_fault_o,
    output logic             irq_o
);

    localparam logic [CNT_W-1:0] AGREE_N = CNT_W'(AGREE_CYCLES);
    localparam logic [CNT_W-1:0] LIMIT_N = CNT_W'(LIMIT_CYCLES);

    mon_regs_s        st_ff;
    mon_regs_s        nxt_st;
    logic             in_a;
    logic             in_b;
    logic             both_on;
    logic             both_off;
    logic             bus_req;
    logic             bus_accept;
    logic             wr_lane;
    logic [2:0]       word_idx;
    logic [31:0]      status_word;
    logic [31:0]      fault_word;
    logic [CNT_W-1:0] cnt_inc;

    // Synchronised channel levels; first stages feed only second stages
    assign in_a     = st_ff.a_sync[1];
    assign in_b     = st_ff.b_sync[1];
    assign both_on  = in_a & in_b;
    assign both_off = ~in_a & ~in_b;
    assign cnt_inc  = (st_ff.cnt == LIMIT_N) ? st_ff.cnt : st_ff.cnt + CNT_W'(1);

    // Bus handshake: first cycle of a request drops waitrequest next edge
    assign bus_req    = (avs_req_i.read | avs_req_i.write) & st_ff.waitreq;
    assign bus_accept = (avs_req_i.read | avs_req_i.write) & ~st_ff.waitreq;
    assign wr_lane    = avs_req_i.write & avs_req_i.byteenable[0];
    assign word_idx   = avs_req_i.address[4:2];

    // Guard status word as software sees it
    always_comb
    begin
        status_word = 32'h0;
        status_word[ST_GUARD_OK]    = ~st_ff.halt & ~st_ff.fault; // RQ13
        status_word[ST_GATE_PERMIT] = st_ff.gate_en; // RQ13
        status_word[ST_INPUTS_ON]   = both_on;
        status_word[ST_HALT_REQ]    = st_ff.halt; // RQ4
        status_word[ST_START_INH]   = st_ff.halt; // RQ4
        fault_word = 32'h0;
        fault_word[FLT_DISCREP] = st_ff.fault;
    end

    // Next-state logic for the whole monitor
    always_comb
    begin
        logic       fault_set;
        logic       fault_clr;
        logic [1:0] events;
        fault_set = 1'b0;
        fault_clr = 1'b0;
        events    = 2'h0;
        nxt_st    = st_ff;
        nxt_st.a_sync = {st_ff.a_sync[0], safe_halt_input_a_i};
        nxt_st.b_sync = {st_ff.b_sync[0], safe_halt_input_b_i};
        nxt_st.cnt    = cnt_inc;

        // Channel agreement tracking; timers only run once a channel drops
        case (st_ff.state)
            ST_RUN:
            begin
                nxt_st.cnt = '0; // RQ12
                if (both_off)
                    nxt_st.state = ST_BOTH_OFF;
                else if (!both_on)
                    nxt_st.state = ST_OFF_WAIT;
            end
            ST_OFF_WAIT:
            begin
                if (both_off)
                begin
                    nxt_st.state = ST_BOTH_OFF;
                    nxt_st.cnt   = '0;
                end
                else if (both_on)
                begin
                    fault_set    = 1'b1; // RQ8
                    nxt_st.state = ST_RUN;
                end
                else if (st_ff.cnt >= AGREE_N - CNT_W'(1))
                    fault_set = 1'b1; // RQ5
            end
            ST_BOTH_OFF:
            begin
                if (both_on)
                    nxt_st.state = ST_RUN;
                else if (!both_off)
                begin
                    nxt_st.state = ST_ON_WAIT;
                    nxt_st.cnt   = '0;
                end
            end
            ST_ON_WAIT:
            begin
                if (both_off)
                begin
                    nxt_st.state = ST_BOTH_OFF;
                    nxt_st.cnt   = '0;
                end
                else if (both_on)
                    nxt_st.state = (st_ff.cnt < AGREE_N) ? ST_RUN : ST_ON_LATE; // RQ7
                else if (st_ff.cnt >= LIMIT_N - CNT_W'(1))
                    fault_set = 1'b1; // RQ6
            end
            ST_ON_LATE:
            begin
                if (!both_on)
                begin
                    nxt_st.state = both_off ? ST_BOTH_OFF : ST_OFF_WAIT;
                    nxt_st.cnt   = '0;
                end
                else if (st_ff.cnt >= LIMIT_N - CNT_W'(1))
                    nxt_st.state = ST_RUN; // RQ7
            end
            default:
            begin
                nxt_st.state = ST_BOTH_OFF;
                nxt_st.cnt   = '0;
            end
        endcase

        // Fault checks only count while the torque-off mode is in force
        fault_set = fault_set & st_ff.hw_mode; // RQ11

        // Reset command needs both channels off past the full limit
        if (bus_accept && wr_lane && word_idx == IDX_CTRL && avs_req_i.writedata[CTRL_FAULT_RST] &&
            st_ff.state == ST_BOTH_OFF && both_off && st_ff.cnt == LIMIT_N)
            fault_clr = 1'b1; // RQ9 RQ10

        // A new fault wins over a reset in the same cycle
        if (fault_set)
            nxt_st.fault = 1'b1;
        else if (fault_clr)
            nxt_st.fault = 1'b0;

        nxt_st.halt    = (nxt_st.state != ST_RUN); // RQ3 RQ4
        // Gates off outside hardwired mode: no network path exists here
        nxt_st.gate_en = nxt_st.hw_mode & ~nxt_st.halt & ~nxt_st.fault; // RQ1 RQ2 RQ13

        // Register writes take effect on the accepting edge
        if (bus_accept && wr_lane)
        begin
            case (word_idx)
                IDX_CTRL:
                    nxt_st.hw_mode = avs_req_i.writedata[CTRL_HW_MODE]; // RQ11
                IDX_IRQ_CLR:
                    nxt_st.irq_status = st_ff.irq_status & ~avs_req_i.writedata[1:0];
                IDX_IRQ_EN:
                    nxt_st.irq_en = avs_req_i.writedata[1:0];
                default:
                    nxt_st.irq_en = st_ff.irq_en;
            endcase
        end
        // Mode change lands on the same edge as the gate decision
        nxt_st.gate_en = nxt_st.hw_mode & ~nxt_st.halt & ~nxt_st.fault; // RQ11

        // Sticky events; setting beats a clear in the same cycle
        events[EV_HALT]   = nxt_st.halt & ~st_ff.halt;
        events[EV_FAULT]  = nxt_st.fault & ~st_ff.fault;
        nxt_st.irq_status = nxt_st.irq_status | events;
        nxt_st.irq        = |(nxt_st.irq_status & nxt_st.irq_en);

        // Bus answer: one wait cycle, read data ready with waitrequest low
        nxt_st.waitreq = ~bus_req;
        if (bus_req && avs_req_i.read)
        begin
            case (word_idx)
                IDX_CTRL:    nxt_st.rdata = {31'h0, st_ff.hw_mode};
                IDX_STATUS:  nxt_st.rdata = status_word;
                IDX_FAULT:   nxt_st.rdata = fault_word;
                IDX_IRQ_ST:  nxt_st.rdata = {30'h0, st_ff.irq_status};
                IDX_IRQ_EN:  nxt_st.rdata = {30'h0, st_ff.irq_en};
                default:     nxt_st.rdata = 32'h0;
            endcase
        end
    end

    // State register
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            st_ff <= REGS_RESET;
        else
            st_ff <= nxt_st;
    end

    // Outputs straight from the state register
    assign avs_readdata_o      = st_ff.rdata;
    assign avs_waitrequest_o   = st_ff.waitreq;
    assign gate_drive_enable_o = st_ff.gate_en;
    assign halt_request_o      = st_ff.halt;
    assign discrepancy_fault_o = st_ff.fault;
    assign irq_o               = st_ff.irq;

    // Checks on the monitor's own behaviour
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n_i);

    a_gate_drop_off: assert property (!both_on |=> !st_ff.gate_en) // RQ1
        else $error("gate left enabled with a channel off");

    a_response_bound: assert property ($fell(st_ff.a_sync[0]) |-> ##[1:3] !st_ff.gate_en) // RQ2
        else $error("torque not disabled in time");

    a_halt_sets: assert property (!both_on |=> st_ff.halt && status_word[ST_START_INH] == 1'b1) // RQ3
        else $error("halt request not raised");

    a_status_pair: assert property (st_ff.halt |-> status_word[ST_HALT_REQ] && status_word[ST_START_INH]) // RQ4
        else $error("status word halt bits disagree");

    a_agree_expire: assert property (st_ff.state == ST_OFF_WAIT && st_ff.cnt == AGREE_N - CNT_W'(1) &&
        !both_on && !both_off && st_ff.hw_mode |=> st_ff.fault) // RQ5
        else $error("discrepancy not posted at window end");

    a_no_fault_return: assert property (st_ff.state == ST_ON_WAIT && both_on && !st_ff.fault
        |=> !st_ff.fault) // RQ6
        else $error("fault posted on timely return");

    a_quick_clear: assert property (st_ff.state == ST_ON_WAIT && both_on && st_ff.cnt < AGREE_N
        |=> !st_ff.halt ##1 !st_ff.halt || !both_on) // RQ7
        else $error("halt not cleared at once");

    a_late_hold: assert property (st_ff.state == ST_ON_LATE && both_on && st_ff.cnt < LIMIT_N - CNT_W'(1)
        |=> st_ff.halt) // RQ7
        else $error("halt cleared before the limit");

    a_early_return: assert property (st_ff.state == ST_OFF_WAIT && both_on && st_ff.hw_mode
        |=> st_ff.fault) // RQ8
        else $error("fault missed on early return");

    a_reset_guard: assert property ($fell(st_ff.fault) |-> $past(st_ff.state) == ST_BOTH_OFF &&
        $past(st_ff.cnt) == LIMIT_N) // RQ9
        else $error("fault cleared too early");

    a_mode_gate: assert property (!st_ff.hw_mode |-> !st_ff.gate_en) // RQ11
        else $error("torque allowed outside hardwired mode");

    a_run_no_check: assert property (st_ff.state == ST_RUN |=> !$rose(st_ff.fault)) // RQ12
        else $error("fault raised with no demand");

    a_guard_not_ok: assert property ((st_ff.halt || st_ff.fault) |-> !st_ff.gate_en &&
        !status_word[ST_GUARD_OK]) // RQ13
        else $error("guard shown OK while halted");

endmodule : safe_halt_monitor

/* File: testbench/safety_device_model.sv */
`timescale 1ns/1ps
// External safety relay: two redundant contacts, high = energized
module safety_device_model
(
    input  wire logic clock_i,
    input  wire logic want_a_i,
    input  wire logic want_b_i,
    output logic      chan_a_o,
    output logic      chan_b_o
);
    // Contacts move on the clock so the bench controls the skew exactly
    always_ff @(posedge clock_i)
    begin
        chan_a_o <= want_a_i;
        chan_b_o <= want_b_i;
    end
endmodule : safety_device_model

/* File: testbench/dual_channel_safe_halt_monitor_tb_top.sv */
`timescale 1ns/1ps
module dual_channel_safe_halt_monitor_tb_top;
    import halt_monitor_pkg::*;
    // Short windows keep the run brief; AG must stay below LM
    localparam int AG = 20;
    localparam int LM = 200;
    logic        clk = 1'b0;
    logic        rst_n;
    logic        want_a;
    logic        want_b;
    logic        in_a;
    logic        in_b;
    avs_req_s    req;
    logic [31:0] rdata;
    logic [31:0] rd;
    logic        wreq;
    logic        gate;
    logic        halt;
    logic        fault;
    logic        irq;
    int          err_total = 0;
    int          checked = 0;

    // 200 MHz clock
    always #2.5 clk = ~clk;

    safety_device_model relay (.clock_i(clk), .want_a_i(want_a), .want_b_i(want_b),
                               .chan_a_o(in_a), .chan_b_o(in_b));

    safe_halt_monitor #(.AGREE_CYCLES(AG), .LIMIT_CYCLES(LM)) dut (
        .clock_i(clk), .rst_n_i(rst_n), .safe_halt_input_a_i(in_a),
        .safe_halt_input_b_i(in_b), .avs_req_i(req), .avs_readdata_o(rdata),
        .avs_waitrequest_o(wreq), .gate_drive_enable_o(gate), .halt_request_o(halt),
        .discrepancy_fault_o(fault), .irq_o(irq));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk

    // One Avalon access; holds the request until waitrequest is seen low
    task automatic bus(input logic wr, input logic [2:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{!wr, wr, {idx, 2'b00}, wd, 4'hF};
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wreq !== 1'b0 && n < 50);
        if (n >= 50)
            chk(1'b0, 1'b1, "bus answer");
        rd = rdata;
        req <= '0;
    endtask : bus

    task automatic rreg(input logic [2:0] idx, input logic [31:0] exp, input string w);
        bus(1'b0, idx, 32'h0);
        chk(rd, exp, w);
    endtask : rreg

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc

    task automatic drive(input logic a, input logic b);
        @(posedge clk);
        want_a <= a;
        want_b <= b;
    endtask : drive

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : final_report

    // Watchdog well beyond the roughly 1100 cycles the tests need
    initial
    begin
        cyc(20000);
        chk(1'b0, 1'b1, "watchdog");
        final_report();
    end

    // Main sequence
    initial
    begin
        want_a = 1'b1;
        want_b = 1'b1;
        req = '0;
        rst_n = 1'b0;
        cyc(6);
        rst_n <= 1'b1;
        chk(gate, 1'b0, "gate at reset");
        chk(halt, 1'b1, "halt at reset");
        chk(fault, 1'b0, "fault at reset");
        chk(irq, 1'b0, "irq at reset");
        rreg(IDX_CTRL, 32'h0, "ctrl reset");
        rreg(3'h7, 32'h0, "unmapped read");
        cyc(8);
        chk(gate, 1'b0, "gate outside hw mode");
        bus(1'b1, IDX_IRQ_EN, 32'h3);
        bus(1'b1, IDX_CTRL, 32'h1);
        cyc(4);
        chk(gate, 1'b1, "gate in hw mode");
        rreg(IDX_STATUS, 32'h0D, "status running");
        $display("Test mode_select done");

        // Both channels drop inside the agreement window
        drive(1'b0, 1'b1);
        cyc(5);
        chk(gate, 1'b0, "gate after drop");
        chk(halt, 1'b1, "halt after drop");
        drive(1'b0, 1'b0);
        cyc(40);
        chk(fault, 1'b0, "agreeing drop");
        rreg(IDX_STATUS, 32'h30, "status halted");
        chk(irq, 1'b1, "irq on halt");
        rreg(IDX_IRQ_ST, 32'h1, "irq status halt");
        bus(1'b1, IDX_IRQ_CLR, 32'h1);
        cyc(2);
        chk(irq, 1'b0, "irq cleared");
        drive(1'b1, 1'b0);
        cyc(10);
        drive(1'b1, 1'b1);
        cyc(6);
        chk(halt, 1'b0, "quick return");
        chk(fault, 1'b0, "quick return");
        chk(gate, 1'b1, "gate restored");
        $display("Test agreeing_stop done");

        // Second channel returns after the short window but inside the long one
        drive(1'b0, 1'b0);
        cyc(10);
        drive(1'b1, 1'b0);
        cyc(50);
        drive(1'b1, 1'b1);
        cyc(100);
        chk(halt, 1'b1, "late return holds");
        cyc(70);
        chk(halt, 1'b0, "late return clears");
        chk(fault, 1'b0, "late return");
        $display("Test late_return done");

        // Second channel never follows the first
        drive(1'b0, 1'b1);
        cyc(12);
        chk(fault, 1'b0, "inside window");
        cyc(20);
        chk(fault, 1'b1, "outside window");
        rreg(IDX_FAULT, 32'h200, "fault word");
        drive(1'b0, 1'b0);
        bus(1'b1, IDX_CTRL, 32'h3);
        cyc(2);
        chk(fault, 1'b1, "early reset refused");
        cyc(LM + 20);
        chk(fault, 1'b1, "no self clear");
        bus(1'b1, IDX_CTRL, 32'h3);
        cyc(2);
        chk(fault, 1'b0, "reset accepted");
        rreg(IDX_CTRL, 32'h1, "reset bit reads 0");
        $display("Test discrepancy done");

        // First channel returns before the second ever dropped
        drive(1'b1, 1'b1);
        cyc(10);
        chk(halt, 1'b0, "running again");
        drive(1'b0, 1'b1);
        cyc(6);
        drive(1'b1, 1'b1);
        cyc(6);
        chk(fault, 1'b1, "early return");
        rreg(IDX_STATUS, 32'h08, "status faulted");
        bus(1'b1, IDX_IRQ_EN, 32'h0);
        cyc(2);
        chk(irq, 1'b0, "irq masked");
        bus(1'b1, IDX_IRQ_EN, 32'h2);
        cyc(2);
        chk(irq, 1'b1, "irq fault enabled");
        bus(1'b1, IDX_IRQ_CLR, 32'h3);
        cyc(2);
        chk(irq, 1'b0, "irq all cleared");
        $display("Test early_return done");

        // Clear the latched fault, then leave the second channel off past the limit
        drive(1'b0, 1'b0);
        cyc(LM + 10);
        bus(1'b1, IDX_CTRL, 32'h3);
        cyc(2);
        chk(fault, 1'b0, "fault reset again");
        drive(1'b1, 1'b0);
        cyc(LM / 2);
        chk(fault, 1'b0, "second channel still inside limit");
        cyc(LM / 2 + 20);
        chk(fault, 1'b1, "second channel never returned");
        $display("Test late_second_channel done");
        final_report();
    end
endmodule : dual_channel_safe_halt_monitor_tb_top
